// ### core/cpes_event_counter.v
// event-select decoder and counter for core performance monitoring
// Behaviour
// - 85H/60H counts second-level translation hits
// - 87H: prefix-length stalls, queue-full stall cycles
// - 88H branch-type bits qualify executed branches
// - FFH on 88H/89H counts all branches
// - 89H counts mispredicted branches, same qualifiers
// - 89H/41H mispredicted not-taken, conditional only
// - 9CH/01H undelivered micro-ops per thread
// - A1H port dispatch cycles, any-thread per core
// - A2H allocation stall cycles by resource
// - A3H/01H pending second-level miss loads, threshold 2
// - A3H/02H pending memory loads, threshold 2
// - A3H/08H first-level misses, counter two only
// - A3H/0CH first-level miss stalls, counter two only
// - A8H/01H loop-buffer delivered micro-ops
// - AEH/01H instruction translation flushes
// - B0H off-core requests by type
// - B1H/02H core micro-ops, no any-thread needed
// - BCH/11H data-walk loads hitting first level
// - threshold one counts cycles not occurrences
// - edge qualifier counts rising transitions only, with a nonzero counter mask
`timescale 1ns/1ps
`default_nettype none

`include "cpes_regs.vh"

module cpes_event_counter #(
    parameter CNT_W   = 48,
    parameter CW      = 4,
    parameter CNT_IDX = 2
) (
    input  wire             clk_sys,
    input  wire             reset,
    // selection from software
    input  wire [7:0]       event_select,
    input  wire [7:0]       unit_mask,
    input  wire [7:0]       count_mask,
    input  wire             invert,
    input  wire             edge_detect,
    input  wire             all_threads_qualifier,
    input  wire             count_enable,
    input  wire             multithreading_mode,
    // condition sources from the pipeline
    input  wire             itrans_miss_second_level_hit,
    input  wire             decode_prefix_length_stall,
    input  wire             decode_queue_full_stall,
    input  wire [5:0]       branch_type_exec,
    input  wire             branch_taken_exec,
    input  wire             branch_mispredicted,
    input  wire [CW-1:0]    undelivered_microop_count,
    input  wire [7:0]       port_dispatch_thread,
    input  wire [7:0]       port_dispatch_core,
    input  wire             stall_any_resource,
    input  wire             stall_reservation_station,
    input  wire             stall_store_buffer,
    input  wire             stall_reorder_buffer,
    input  wire [CW-1:0]    pending_l2_miss_loads,
    input  wire [CW-1:0]    pending_memory_loads,
    input  wire [CW-1:0]    pending_l1d_miss_loads,
    input  wire [CW-1:0]    stall_l1d_miss_loads,
    input  wire [CW-1:0]    loop_buffer_delivered_microops,
    input  wire             itrans_flush_count,
    input  wire             req_demand_data,
    input  wire             req_demand_code,
    input  wire             req_demand_own,
    input  wire             req_all_data,
    input  wire [CW-1:0]    core_microops_executed,
    input  wire             outbound_response_event_zero,
    input  wire             outbound_response_event_one,
    input  wire             data_walk_load_first_level_hit,
    // results
    output wire             select_valid,
    output wire             usage_warning,
    output wire [CNT_W-1:0] counter_value
);

    // ********************************************
    // helpers
    // ********************************************

    // one pulse widened to a per-cycle count
    function [CW-1:0] one;
        input bit_in;
        begin
            one = {{(CW-1){1'b0}}, bit_in};
        end
    endfunction

    // branch qualifier match shared by the executed and mispredicted events
    function br_match;
        input [7:0] um;
        input [5:0] btype;
        input       taken;
        reg         type_hit;
        begin
            type_hit = |(um[5:0] & btype);
            if (um == `CPES_UM_BR_ALL)
                br_match = |btype;
            else
                br_match = type_hit &
                           ((um[7] & taken) | (um[6] & ~taken & btype[0]));
        end
    endfunction

    // legal branch qualifier combination
    function br_legal;
        input [7:0] um;
        begin
            if (um == `CPES_UM_BR_ALL)
                br_legal = 1'b1;
            else
                br_legal = (|um[5:0]) & (um[7] | um[6]) &
                           (~um[6] | (um[5:0] == `CPES_UM_BR_COND));
        end
    endfunction

    // ********************************************
    // source selection
    // ********************************************

    reg [CW-1:0] raw_count;
    reg          sel_hit;
    reg          warn;
    reg  [3:0]   port_sum;
    integer      i;

    // dispatch cycles per port; core view when all threads requested
    always @*
    begin
        port_sum = 4'h0;
        for (i = 0; i < 8; i = i + 1)
            port_sum = port_sum + {3'b000, unit_mask[i] &
                       (all_threads_qualifier ? port_dispatch_core[i] : port_dispatch_thread[i])};
    end

    // event and unit-mask decode; anything unmatched counts zero
    always @*
    begin
        raw_count = {CW{1'b0}};
        sel_hit   = 1'b0;
        warn      = 1'b0;
        case (event_select)
            `CPES_EV_ITRANS_MISS:
                if (unit_mask == `CPES_UM_SECOND_LEVEL_HIT)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(itrans_miss_second_level_hit);
                end
            `CPES_EV_DECODE_STALL:
                if (unit_mask == `CPES_UM_PREFIX_STALL)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(decode_prefix_length_stall);
                end
                else if (unit_mask == `CPES_UM_QUEUE_FULL)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(decode_queue_full_stall);
                end
            `CPES_EV_BR_EXEC:
                if (br_legal(unit_mask))
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(br_match(unit_mask, branch_type_exec, branch_taken_exec));
                end
            `CPES_EV_BR_MISP:
                if (br_legal(unit_mask))
                begin
                    sel_hit   = 1'b1;
                    // the all-branches mask takes every executed branch, predicted or not
                    raw_count = one((branch_mispredicted | (unit_mask == `CPES_UM_BR_ALL)) &
                                    br_match(unit_mask, branch_type_exec, branch_taken_exec));
                end
            `CPES_EV_UNDELIVERED:
                if (unit_mask == `CPES_UM_ONE)
                begin
                    sel_hit   = 1'b1;
                    raw_count = undelivered_microop_count;
                end
            `CPES_EV_PORT_DISPATCH:
                if (unit_mask != 8'h00)
                begin
                    sel_hit   = 1'b1;
                    raw_count = port_sum[CW-1:0];
                end
            `CPES_EV_RESOURCE_STALL:
                if (unit_mask == `CPES_UM_RS_ANY)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(stall_any_resource);
                end
                else if (unit_mask == `CPES_UM_RS_STATION)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(stall_reservation_station);
                end
                else if (unit_mask == `CPES_UM_RS_STORE_BUF)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(stall_store_buffer);
                end
                else if (unit_mask == `CPES_UM_RS_REORDER)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(stall_reorder_buffer);
                end
            `CPES_EV_MISS_PENDING:
                if (unit_mask == `CPES_UM_PEND_L2)
                begin
                    sel_hit   = 1'b1;
                    warn      = multithreading_mode;
                    raw_count = pending_l2_miss_loads;
                end
                else if (unit_mask == `CPES_UM_PEND_MEM)
                begin
                    sel_hit   = 1'b1;
                    raw_count = pending_memory_loads;
                end
                // only counter two carries the first-level miss sources
                else if (unit_mask == `CPES_UM_PEND_L1D && CNT_IDX == `CPES_COUNTER_TWO)
                begin
                    sel_hit   = 1'b1;
                    raw_count = pending_l1d_miss_loads;
                end
                else if (unit_mask == `CPES_UM_STALL_L1D && CNT_IDX == `CPES_COUNTER_TWO)
                begin
                    sel_hit   = 1'b1;
                    raw_count = stall_l1d_miss_loads;
                end
            `CPES_EV_LOOP_BUFFER:
                if (unit_mask == `CPES_UM_ONE)
                begin
                    sel_hit   = 1'b1;
                    raw_count = loop_buffer_delivered_microops;
                end
            `CPES_EV_ITRANS_FLUSH:
                if (unit_mask == `CPES_UM_ONE)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(itrans_flush_count);
                end
            `CPES_EV_OUTBOUND_REQ:
            begin
                warn = multithreading_mode;
                if (unit_mask == `CPES_UM_REQ_DATA)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(req_demand_data);
                end
                else if (unit_mask == `CPES_UM_REQ_CODE)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(req_demand_code);
                end
                else if (unit_mask == `CPES_UM_REQ_OWN)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(req_demand_own);
                end
                else if (unit_mask == `CPES_UM_REQ_ALL_DATA)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(req_all_data);
                end
                else
                    warn = 1'b0;
            end
            `CPES_EV_CORE_UOPS:
                if (unit_mask == `CPES_UM_CORE_UOPS)
                begin
                    sel_hit   = 1'b1;
                    raw_count = core_microops_executed;
                end
            // the response filters live outside; the source is already filtered
            `CPES_EV_OUTBOUND_RESP0:
                if (unit_mask == `CPES_UM_ONE)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(outbound_response_event_zero);
                end
            `CPES_EV_OUTBOUND_RESP1:
                if (unit_mask == `CPES_UM_ONE)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(outbound_response_event_one);
                end
            `CPES_EV_WALK_LOADS:
                if (unit_mask == `CPES_UM_WALK_L1_DATA)
                begin
                    sel_hit   = 1'b1;
                    raw_count = one(data_walk_load_first_level_hit);
                end
            default:
            begin
                sel_hit   = 1'b0;
                raw_count = {CW{1'b0}};
            end
        endcase
    end

    // ********************************************
    // qualification and counting
    // ********************************************

    wire [CW-1:0]    qual_count;
    reg  [CNT_W-1:0] count_reg;
    reg  [CNT_W-1:0] count_next;

    cpes_qualifier #(
        .CW (CW)
    ) u_qualifier (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .raw_count   (raw_count),
        .count_mask  (count_mask),
        .invert      (invert),
        .edge_detect (edge_detect),
        .qual_count  (qual_count)
    );

    // an invalid selection never counts, even with invert set
    always @*
    begin
        count_next = count_reg;
        if (count_enable && sel_hit)
            count_next = count_reg + {{(CNT_W-CW){1'b0}}, qual_count};
    end

    // counter storage, wraps silently
    always @(posedge clk_sys)
    begin
        if (reset)
            count_reg <= `CPES_COUNT_RESET;
        else
            count_reg <= count_next;
    end

    assign counter_value = count_reg;
    assign select_valid  = sel_hit;
    assign usage_warning = warn;

endmodule

`default_nettype wire

// ### core/cpes_regs.vh
// event and unit-mask encodings, counter qualifiers for the event-select decoder
`ifndef CPES_REGS_VH
`define CPES_REGS_VH

// event numbers
`define CPES_EV_ITRANS_MISS      8'h85
`define CPES_EV_DECODE_STALL     8'h87
`define CPES_EV_BR_EXEC          8'h88
`define CPES_EV_BR_MISP          8'h89
`define CPES_EV_UNDELIVERED      8'h9c
`define CPES_EV_PORT_DISPATCH    8'ha1
`define CPES_EV_RESOURCE_STALL   8'ha2
`define CPES_EV_MISS_PENDING     8'ha3
`define CPES_EV_LOOP_BUFFER      8'ha8
`define CPES_EV_ITRANS_FLUSH     8'hae
`define CPES_EV_OUTBOUND_REQ     8'hb0
`define CPES_EV_CORE_UOPS        8'hb1
`define CPES_EV_OUTBOUND_RESP0   8'hb7
`define CPES_EV_OUTBOUND_RESP1   8'hbb
`define CPES_EV_WALK_LOADS       8'hbc

// unit masks
`define CPES_UM_SECOND_LEVEL_HIT 8'h60
`define CPES_UM_PREFIX_STALL     8'h01
`define CPES_UM_QUEUE_FULL       8'h04
`define CPES_UM_BR_TYPE_MASK     8'h3f
`define CPES_UM_BR_COND          8'h01
`define CPES_UM_BR_NOT_TAKEN     8'h40
`define CPES_UM_BR_TAKEN         8'h80
`define CPES_UM_BR_ALL           8'hff
`define CPES_UM_ONE              8'h01
`define CPES_UM_CORE_UOPS        8'h02
`define CPES_UM_RS_ANY           8'h01
`define CPES_UM_RS_STATION       8'h04
`define CPES_UM_RS_STORE_BUF     8'h08
`define CPES_UM_RS_REORDER       8'h10
`define CPES_UM_PEND_L2          8'h01
`define CPES_UM_PEND_MEM         8'h02
`define CPES_UM_PEND_L1D         8'h08
`define CPES_UM_STALL_L1D        8'h0c
`define CPES_UM_REQ_DATA         8'h01
`define CPES_UM_REQ_CODE         8'h02
`define CPES_UM_REQ_OWN          8'h04
`define CPES_UM_REQ_ALL_DATA     8'h08
`define CPES_UM_WALK_L1_DATA     8'h11

// counter index that alone supports the first-level miss encodings
`define CPES_COUNTER_TWO         2'd2

// reset values
`define CPES_COUNT_RESET         48'h000000000000

`endif

// ### core/cpes_qualifier.v
// counter-mask threshold, invert and edge qualification of a per-cycle count
`timescale 1ns/1ps
`default_nettype none

module cpes_qualifier #(
    parameter CW = 4
) (
    input  wire          clk_sys,
    input  wire          reset,
    input  wire [CW-1:0] raw_count,
    input  wire [7:0]    count_mask,
    input  wire          invert,
    input  wire          edge_detect,
    output wire [CW-1:0] qual_count
);

    reg        cond_prev_reg;
    wire [7:0] raw_wide;
    wire       cond;
    wire       cond_rise;

    // a zero threshold passes the raw count, otherwise one cycle per hit
    assign raw_wide  = {{(8-CW){1'b0}}, raw_count};
    assign cond      = invert ? (raw_wide < count_mask) : (raw_wide >= count_mask);
    assign cond_rise = cond & ~cond_prev_reg;

    // edge memory; the first cycle after reset sees a clean low history
    always @(posedge clk_sys)
    begin
        if (reset)
            cond_prev_reg <= 1'b0;
        else
            cond_prev_reg <= cond;
    end

    assign qual_count = (count_mask == 8'h00) ? raw_count :
                        edge_detect ? {{(CW-1){1'b0}}, cond_rise} :
                        {{(CW-1){1'b0}}, cond};

endmodule

`default_nettype wire

// ### verification/cpes_event_counter_monitor.sv
// assertion checker for the event-select counter ports
`timescale 1ns/1ps
`default_nettype none

module cpes_event_counter_monitor #(
    parameter CNT_W = 48
) (
    input wire logic             clk_sys,
    input wire logic             reset,
    input wire logic [7:0]       event_select,
    input wire logic [7:0]       unit_mask,
    input wire logic [7:0]       count_mask,
    input wire logic             invert,
    input wire logic             edge_detect,
    input wire logic             count_enable,
    input wire logic             multithreading_mode,
    input wire logic             itrans_miss_second_level_hit,
    input wire logic             decode_queue_full_stall,
    input wire logic             branch_mispredicted,
    input wire logic             itrans_flush_count,
    input wire logic             select_valid,
    input wire logic             usage_warning,
    input wire logic [CNT_W-1:0] counter_value
);
    // ****************
    // properties
    // ****************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    reset_clears_a: assert property ($fell(reset) |-> counter_value == '0)
        else $error("counter not cleared by reset");
    disabled_holds_a: assert property (!count_enable |=> $stable(counter_value))
        else $error("counter moved while disabled");
    invalid_holds_a: assert property (!select_valid |=> $stable(counter_value))
        else $error("counter moved on an unlisted selection");
    unlisted_mask_a: assert property (event_select == 8'h85 && unit_mask != 8'h60 |-> !select_valid)
        else $error("unlisted mask accepted");
    hit_counts_a: assert property (count_enable && event_select == 8'h85 && unit_mask == 8'h60
        && count_mask == 8'h00 && itrans_miss_second_level_hit |=> counter_value == $past(counter_value) + 1'b1)
        else $error("translation hit not counted once");
    flush_counts_a: assert property (count_enable && event_select == 8'hae && unit_mask == 8'h01
        && count_mask == 8'h00 && itrans_flush_count |-> ##1 counter_value - $past(counter_value) == 1)
        else $error("flush not counted once");
    queue_cycles_a: assert property (count_enable && event_select == 8'h87 && unit_mask == 8'h04
        && count_mask == 8'h01 && !invert && !edge_detect && decode_queue_full_stall
        |=> counter_value == $past(counter_value) + 1'b1)
        else $error("threshold one did not count the cycle");
    misp_only_a: assert property (count_enable && event_select == 8'h89 && unit_mask == 8'h81
        && count_mask == 8'h00 && !branch_mispredicted |=> $stable(counter_value))
        else $error("predicted branch counted as mispredicted");
    edge_once_a: assert property (count_enable && edge_detect && !invert && count_mask == 8'h01
        && event_select == 8'h85 && unit_mask == 8'h60 && itrans_miss_second_level_hit
        && $past(itrans_miss_second_level_hit) && $past(event_select) == 8'h85 && $past(unit_mask) == 8'h60
        && $past(count_mask) == 8'h01 && !$past(invert) && !$past(reset) |=> $stable(counter_value))
        else $error("edge mode counted a held condition");
    usage_flag_a: assert property (usage_warning == (multithreading_mode && select_valid
        && (event_select == 8'hb0 || (event_select == 8'ha3 && unit_mask == 8'h01))))
        else $error("usage warning wrong");
endmodule

bind cpes_event_counter cpes_event_counter_monitor #(.CNT_W(CNT_W)) mon (.clk_sys(clk_sys), .reset(reset),
    .event_select(event_select), .unit_mask(unit_mask), .count_mask(count_mask), .invert(invert),
    .edge_detect(edge_detect), .count_enable(count_enable), .multithreading_mode(multithreading_mode),
    .itrans_miss_second_level_hit(itrans_miss_second_level_hit), .decode_queue_full_stall(decode_queue_full_stall),
    .branch_mispredicted(branch_mispredicted), .itrans_flush_count(itrans_flush_count),
    .select_valid(select_valid), .usage_warning(usage_warning), .counter_value(counter_value));

`default_nettype wire

// ### verification/cpes_pipeline_model.sv
// pipeline model: drives a burst of condition sources for a set number of cycles
`timescale 1ns/1ps
`default_nettype none

module cpes_pipeline_model #(
    parameter W = 67
) (
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic         go,
    input  wire logic [W-1:0] pat,
    input  wire logic [7:0]   n,
    output var  logic [W-1:0] src_reg,
    output wire logic         busy
);
    logic [7:0] cnt_reg;

    // sources fall to zero between bursts: zero means no condition this cycle
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            cnt_reg <= 8'h00;
            src_reg <= '0;
        end
        else if (go)
        begin
            cnt_reg <= n;
            src_reg <= pat;
        end
        else if (cnt_reg > 8'h01)
            cnt_reg <= cnt_reg - 8'h01;
        else
        begin
            cnt_reg <= 8'h00;
            src_reg <= '0;
        end
    end

    assign busy = (cnt_reg != 8'h00); // burst still on the wires
endmodule

`default_nettype wire

// ### verification/cpes_event_counter_tb_top.sv
// self-checking bench for the event-select counter
`timescale 1ns/1ps
`default_nettype none

module cpes_event_counter_tb_top;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  ev = 8'h00, um = 8'h00, cm = 8'h00, n = 8'h01;
    logic        inv = 1'b0, edg = 1'b0, any = 1'b0, en = 1'b1, mt = 1'b0, go = 1'b0;
    logic [66:0] pat = '0;
    wire  [66:0] src;
    wire         busy, select_valid, usage_warning;
    wire  [47:0] counter_value;
    logic [7:0]  rs_um [0:3] = '{8'h01, 8'h04, 8'h08, 8'h10};
    logic [7:0]  rq_um [0:3] = '{8'h01, 8'h02, 8'h04, 8'h08};
    int          num_errors = 0, checked = 0, i;

    always #5 clk_sys = ~clk_sys;

    cpes_pipeline_model #(.W(67)) pipe (.clk_sys(clk_sys), .reset(reset), .go(go), .pat(pat), .n(n),
        .src_reg(src), .busy(busy));

    cpes_event_counter dut (.clk_sys(clk_sys), .reset(reset), .event_select(ev), .unit_mask(um),
        .count_mask(cm), .invert(inv), .edge_detect(edg), .all_threads_qualifier(any), .count_enable(en),
        .multithreading_mode(mt), .itrans_miss_second_level_hit(src[66]), .decode_prefix_length_stall(src[65]),
        .decode_queue_full_stall(src[64]), .branch_type_exec(src[63:58]), .branch_taken_exec(src[57]),
        .branch_mispredicted(src[56]), .undelivered_microop_count(src[55:52]), .port_dispatch_thread(src[51:44]),
        .port_dispatch_core(src[43:36]), .stall_any_resource(src[35]), .stall_reservation_station(src[34]),
        .stall_store_buffer(src[33]), .stall_reorder_buffer(src[32]), .pending_l2_miss_loads(src[31:28]),
        .pending_memory_loads(src[27:24]), .pending_l1d_miss_loads(src[23:20]), .stall_l1d_miss_loads(src[19:16]),
        .loop_buffer_delivered_microops(src[15:12]), .itrans_flush_count(src[11]), .req_demand_data(src[10]),
        .req_demand_code(src[9]), .req_demand_own(src[8]), .req_all_data(src[7]),
        .core_microops_executed(src[6:3]), .outbound_response_event_zero(src[2]),
        .outbound_response_event_one(src[1]), .data_walk_load_first_level_hit(src[0]),
        .select_valid(select_valid), .usage_warning(usage_warning), .counter_value(counter_value));

    // ****************
    // compare and closing tasks
    // ****************
    task automatic cmp_cnt(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // select, fire one burst, then compare the counter growth; waits on the model's busy, bounded
    task automatic run(input logic [7:0] e, input logic [7:0] u, input int pos, input logic [7:0] v,
                       input logic [7:0] cyc, input logic [7:0] exp, input logic [7:0] c = 8'h00,
                       input logic [2:0] fl = 3'h0);
        logic [47:0] c0;
        int          k;
        ev = e;
        um = u;
        cm = c;
        {inv, edg, any} = fl;
        @(posedge clk_sys);
        #1;
        c0 = counter_value;
        pat = 67'(v) << pos;
        n = cyc;
        go = 1'b1;
        @(posedge clk_sys);
        #1;
        go = 1'b0;
        k = 0;
        while (busy && k < 300)
        begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        // a burst that never ends counts as a mismatch
        if (k >= 300)
            num_errors++;
        @(posedge clk_sys);
        #1;
        cmp_cnt(counter_value - c0, {40'h0, exp});
    endtask

    // ****************
    // test sequence
    // ****************
    initial
    begin
        repeat (3) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        run(8'h85, 8'h60, 66, 8'h01, 8'h05, 8'h05);
        cmp_bit(select_valid, 1'b1);
        run(8'h87, 8'h01, 65, 8'h01, 8'h03, 8'h03);
        run(8'h87, 8'h04, 64, 8'h01, 8'h03, 8'h03, 8'h01);
        for (i = 0; i < 6; i++)
        begin
            run(8'h88, 8'h80 | (8'h01 << i), 56, {6'h01 << i, 2'h2}, 8'h02, 8'h02);
            if (i != 1)
                run(8'h89, 8'h80 | (8'h01 << i), 56, {6'h01 << i, 2'h3}, 8'h02, 8'h02);
        end
        run(8'h88, 8'h81, 56, 8'h04, 8'h03, 8'h00);
        run(8'h88, 8'h41, 56, 8'h04, 8'h03, 8'h03);
        run(8'h88, 8'h42, 56, 8'h08, 8'h03, 8'h00);
        cmp_bit(select_valid, 1'b0);
        run(8'h88, 8'h01, 56, 8'h06, 8'h03, 8'h00);
        run(8'h88, 8'hff, 56, 8'h22, 8'h03, 8'h03);
        run(8'h89, 8'hff, 56, 8'h0a, 8'h03, 8'h03);
        run(8'h89, 8'h81, 56, 8'h06, 8'h03, 8'h00);
        run(8'h89, 8'h41, 56, 8'h05, 8'h03, 8'h03);
        run(8'h9c, 8'h01, 52, 8'h03, 8'h04, 8'h0c);
        run(8'h9c, 8'h01, 52, 8'h03, 8'h04, 8'h04, 8'h02);
        run(8'h9c, 8'h01, 52, 8'h03, 8'h04, 8'h04, 8'h01);
        run(8'h9c, 8'h01, 52, 8'h03, 8'h04, 8'h00, 8'h04);
        run(8'h9c, 8'h01, 52, 8'h03, 8'h04, 8'h06, 8'h04, 3'h4);
        run(8'ha1, 8'h01, 44, 8'h01, 8'h03, 8'h03);
        run(8'ha1, 8'h80, 44, 8'h80, 8'h03, 8'h03);
        run(8'ha1, 8'h05, 44, 8'h05, 8'h03, 8'h06);
        run(8'ha1, 8'h01, 36, 8'h01, 8'h03, 8'h03, 8'h00, 3'h1);
        run(8'ha1, 8'h01, 36, 8'h01, 8'h03, 8'h00);
        for (i = 0; i < 4; i++)
            run(8'ha2, rs_um[i], 35 - i, 8'h01, 8'h02, 8'h02);
        mt = 1'b1;
        run(8'ha3, 8'h01, 28, 8'h02, 8'h03, 8'h03, 8'h02);
        cmp_bit(usage_warning, 1'b1);
        run(8'ha3, 8'h01, 28, 8'h01, 8'h03, 8'h00, 8'h02);
        run(8'ha3, 8'h02, 24, 8'h03, 8'h03, 8'h03, 8'h02);
        run(8'ha3, 8'h08, 20, 8'h08, 8'h03, 8'h03, 8'h08);
        run(8'ha3, 8'h0c, 16, 8'h0c, 8'h03, 8'h03, 8'h0c);
        for (i = 0; i < 4; i++)
            run(8'hb0, rq_um[i], 10 - i, 8'h01, 8'h02, 8'h02);
        cmp_bit(usage_warning, 1'b1);
        mt = 1'b0;
        run(8'ha8, 8'h01, 12, 8'h05, 8'h02, 8'h0a);
        run(8'hae, 8'h01, 11, 8'h01, 8'h03, 8'h03);
        run(8'hb1, 8'h02, 3, 8'h06, 8'h02, 8'h0c);
        run(8'hb7, 8'h01, 2, 8'h01, 8'h03, 8'h03);
        run(8'hbb, 8'h01, 1, 8'h01, 8'h03, 8'h03);
        run(8'hbc, 8'h11, 0, 8'h01, 8'h03, 8'h03);
        run(8'h85, 8'h60, 66, 8'h01, 8'h04, 8'h01, 8'h01, 3'h2);
        run(8'h85, 8'h20, 66, 8'h01, 8'h03, 8'h00);
        cmp_bit(select_valid, 1'b0);
        run(8'hbc, 8'h21, 0, 8'h01, 8'h03, 8'h00);
        en = 1'b0;
        run(8'h85, 8'h60, 66, 8'h01, 8'h03, 8'h00);
        en = 1'b1;
        // mid-run reset must clear the accumulated count
        reset = 1'b1;
        @(posedge clk_sys);
        #1;
        reset = 1'b0;
        cmp_cnt(counter_value, 48'h0);
        wrap_up;
    end

    // watchdog well past the expected few hundred cycles
    initial
    begin
        #50000;
        num_errors++;
        wrap_up;
    end
endmodule

`default_nettype wire
